// >>> monitor_solo_pkg.sv
// Constants, register map and carrier types of the monitor and solo control block
// Behaviour
// - Control room feeds analog, optionally one digital set
// - Four control room keys: stereo plus three
// - Stereo key always selects stereo bus
// - Soft keys default aux1-2, digital1, two-track
// - Soft keys take aux, bus, pairs, inputs
// - One source may sit on several keys
// - Linked follow: odd member left, even right
// - Dim on two-track monitoring is a fixed 30 dB
// - Two-track unmonitorable while feed goes digital; an independent studio still gets it unmuted
// - Studio follow copies control room source
// - Independent studio takes stereo, pairs, inputs
// - Studio level silence up to +10 dB
// - Only the 32 input channels solo
// - Solo needs master solo and one channel
// - Mix mode sums every soloed channel
// - Exclusive mode keeps last pressed channel only
// - Linked group master toggles whole group
// - Group slave press affects slave alone
// - Pre-fader tap goes to monitors only
// - After-fader tap, pre-pan, goes to monitors
// - In-place solo cuts unsoloed channels from stereo
// - Cut-exempt channels never cut in-place
// - Dim attenuation 0 to 40 dB, 1 dB
package monitor_solo_pkg;
  localparam int NUM_CH = 32;
  localparam int NUM_GRP = 8;
  // Register byte offsets
  localparam logic [7:0] OFS_MON_CTRL = 8'h00;
  localparam logic [7:0] OFS_KEY_SRC = 8'h04;
  localparam logic [7:0] OFS_LEVELS = 8'h08;
  localparam logic [7:0] OFS_SOLO_CTRL = 8'h0c;
  localparam logic [7:0] OFS_SOLO_PRESS = 8'h10;
  localparam logic [7:0] OFS_SOLO_DEFEAT = 8'h14;
  localparam logic [7:0] OFS_GROUP_SEL = 8'h18;
  localparam logic [7:0] OFS_GROUP_MEMBERS = 8'h1c;
  localparam logic [7:0] OFS_GROUP_MASTER = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  // Source codes
  localparam logic [4:0] SRC_STEREO = 5'h00;
  localparam logic [4:0] SRC_AUX1 = 5'h01;
  localparam logic [4:0] SRC_AUX12 = 5'h07;
  localparam logic [4:0] SRC_AUX56 = 5'h09;
  localparam logic [4:0] SRC_BUS1 = 5'h0a;
  localparam logic [4:0] SRC_BUS8 = 5'h11;
  localparam logic [4:0] SRC_BUS12 = 5'h12;
  localparam logic [4:0] SRC_DIN1 = 5'h16;
  localparam logic [4:0] SRC_2TR = 5'h18;
  // Levels
  localparam logic [5:0] DIM_MAX_DB = 6'h28;
  localparam logic [5:0] DIM_2TR_DB = 6'h1e;
  // Studio level code: 0 silence, else gain = code - 0x80 dB
  localparam logic [7:0] STUDIO_LVL_MAX = 8'h8a;
  // Control field values
  localparam logic [1:0] DIG_NONE = 2'h0;
  localparam logic [1:0] DIG_SET1 = 2'h1;
  localparam logic [1:0] DIG_SET2 = 2'h2;
  localparam logic [1:0] LINK_OFF = 2'h0;
  localparam logic [1:0] LINK_MUTE = 2'h1;
  localparam logic [1:0] LINK_FADER = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    SOLO_PFL = 2'b00,
    SOLO_AFL = 2'b01,
    SOLO_INPLACE = 2'b10
  } solo_type_t;
  typedef struct packed {
    logic [4:0] crLeft;
    logic [4:0] crRight;
    logic [4:0] studioLeft;
    logic [4:0] studioRight;
    logic crMuted;
    logic studioMuted;
    logic digOut1;
    logic digOut2;
    logic [5:0] dimAtten;
    logic [7:0] studioLevel;
  } monitor_out_t;
  typedef struct packed {
    logic active;
    logic [31:0] preFaderTap;
    logic [31:0] afterFaderTap;
    logic [31:0] stereoCut;
  } solo_out_t;
endpackage

// >>> monitor_source_and_solo_control.sv
// Monitor source selection and solo engine with AXI4-Lite register slave
//
// Our own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
module monitor_source_and_solo_control (
  input wire logic clk,
  input wire logic rst,
  input wire logic sampleTick,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output monitor_solo_pkg::monitor_out_t mon,
  output monitor_solo_pkg::solo_out_t solo
);
  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------
  logic [1:0] crKey_ff;
  logic [1:0] crDig_ff;
  logic studioFollow_ff;
  logic followLink_ff;
  logic dimOn_ff;
  logic [4:0] studioSrc_ff;
  logic [4:0] keySrc_ff [3];
  logic [5:0] dimLevel_ff;
  logic [7:0] studioLvl_ff;
  logic soloOn_ff;
  logic soloExcl_ff;
  logic [1:0] soloLink_ff;
  monitor_solo_pkg::solo_type_t soloType_ff;
  logic [31:0] soloMask_ff;
  logic [31:0] defeat_ff;
  logic [3:0] grpSel_ff;
  logic [31:0] grpMem_ff [16];
  logic [5:0] grpMaster_ff [16];
  // ---------------------------------------------------------------
  // AXI4-Lite write channel
  // ---------------------------------------------------------------
  logic awHeld_ff;
  logic wHeld_ff;
  logic [7:0] awAddr_ff;
  logic [31:0] wData_ff;
  logic [3:0] wStrb_ff;
  logic doWrite;
  logic wrHit;
  assign s_axi_awready = !awHeld_ff && !s_axi_bvalid;
  assign s_axi_wready = !wHeld_ff && !s_axi_bvalid;
  assign doWrite = awHeld_ff && wHeld_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      awHeld_ff <= 1'b0;
      wHeld_ff <= 1'b0;
      awAddr_ff <= 8'h00;
      wData_ff <= 32'h0000_0000;
      wStrb_ff <= 4'h0;
    end else if (doWrite) begin
      awHeld_ff <= 1'b0;
      wHeld_ff <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_ff <= 1'b1;
        awAddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_ff <= 1'b1;
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= monitor_solo_pkg::RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wrHit ? monitor_solo_pkg::RESP_OKAY : monitor_solo_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end
  // Byte-lane merge of write data over a current value
  function automatic logic [31:0] merge(input logic [31:0] cur);
    logic [31:0] res;
    res = cur;
    for (int b = 0; b < 4; b++) begin
      if (wStrb_ff[b]) res[b*8 +: 8] = wData_ff[b*8 +: 8];
    end
    return res;
  endfunction
  function automatic logic keyable(input logic [4:0] s);
    return s != monitor_solo_pkg::SRC_STEREO && s <= monitor_solo_pkg::SRC_2TR;
  endfunction
  function automatic logic studioable(input logic [4:0] s);
    logic ok;
    ok = s == monitor_solo_pkg::SRC_STEREO;
    ok = ok || (s >= monitor_solo_pkg::SRC_AUX12 && s <= monitor_solo_pkg::SRC_AUX56);
    ok = ok || (s >= monitor_solo_pkg::SRC_BUS12 && s <= monitor_solo_pkg::SRC_2TR);
    return ok;
  endfunction
  logic [31:0] wCtrl;
  logic [31:0] wKeys;
  logic [31:0] wLvl;
  logic [31:0] wSolo;
  logic [31:0] wGrp;
  logic selCtrl;
  logic selKeys;
  logic selLvl;
  logic selSolo;
  logic selPress;
  logic selDefeat;
  logic selGrp;
  logic selMem;
  logic selMaster;
  always_comb begin
    selCtrl = 1'b0;
    selKeys = 1'b0;
    selLvl = 1'b0;
    selSolo = 1'b0;
    selPress = 1'b0;
    selDefeat = 1'b0;
    selGrp = 1'b0;
    selMem = 1'b0;
    selMaster = 1'b0;
    if (awAddr_ff == monitor_solo_pkg::OFS_MON_CTRL) selCtrl = 1'b1;
    else if (awAddr_ff == monitor_solo_pkg::OFS_KEY_SRC) selKeys = 1'b1;
    else if (awAddr_ff == monitor_solo_pkg::OFS_LEVELS) selLvl = 1'b1;
    else if (awAddr_ff == monitor_solo_pkg::OFS_SOLO_CTRL) selSolo = 1'b1;
    else if (awAddr_ff == monitor_solo_pkg::OFS_SOLO_PRESS) selPress = 1'b1;
    else if (awAddr_ff == monitor_solo_pkg::OFS_SOLO_DEFEAT) selDefeat = 1'b1;
    else if (awAddr_ff == monitor_solo_pkg::OFS_GROUP_SEL) selGrp = 1'b1;
    else if (awAddr_ff == monitor_solo_pkg::OFS_GROUP_MEMBERS) selMem = 1'b1;
    else if (awAddr_ff == monitor_solo_pkg::OFS_GROUP_MASTER) selMaster = 1'b1;
  end
  // Status is read-only, so a write to it is refused
  assign wrHit = selCtrl | selKeys | selLvl | selSolo | selPress | selDefeat | selGrp
                 | selMem | selMaster;
  assign wCtrl = merge({19'h0, studioSrc_ff, 1'b0, dimOn_ff, followLink_ff, studioFollow_ff,
                        crDig_ff, crKey_ff});
  assign wKeys = merge({11'h0, keySrc_ff[2], 3'h0, keySrc_ff[1], 3'h0, keySrc_ff[0]});
  assign wLvl = merge({16'h0, studioLvl_ff, 2'h0, dimLevel_ff});
  assign wSolo = merge({26'h0, soloType_ff, soloLink_ff, soloExcl_ff, soloOn_ff});
  assign wGrp = merge({28'h0, grpSel_ff});
  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      crKey_ff <= 2'h0;
      crDig_ff <= monitor_solo_pkg::DIG_NONE;
      studioFollow_ff <= 1'b1;
      followLink_ff <= 1'b0;
      dimOn_ff <= 1'b0;
      studioSrc_ff <= monitor_solo_pkg::SRC_STEREO;
    end else if (doWrite && selCtrl) begin
      crKey_ff <= wCtrl[1:0];
      if (wCtrl[3:2] != 2'h3) crDig_ff <= wCtrl[3:2];
      studioFollow_ff <= wCtrl[4];
      followLink_ff <= wCtrl[5];
      dimOn_ff <= wCtrl[6];
      if (studioable(wCtrl[12:8])) studioSrc_ff <= wCtrl[12:8];
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      keySrc_ff[0] <= monitor_solo_pkg::SRC_AUX12;
      keySrc_ff[1] <= monitor_solo_pkg::SRC_DIN1;
      keySrc_ff[2] <= monitor_solo_pkg::SRC_2TR;
    end else if (doWrite && selKeys) begin
      // Keys are independent, so duplicates are allowed
      if (keyable(wKeys[4:0])) keySrc_ff[0] <= wKeys[4:0];
      if (keyable(wKeys[12:8])) keySrc_ff[1] <= wKeys[12:8];
      if (keyable(wKeys[20:16])) keySrc_ff[2] <= wKeys[20:16];
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      dimLevel_ff <= 6'h00;
      studioLvl_ff <= 8'h00;
    end else if (doWrite && selLvl) begin
      if (wLvl[5:0] <= monitor_solo_pkg::DIM_MAX_DB) dimLevel_ff <= wLvl[5:0];
      // Clamp rather than refuse: the knob simply stops at the top
      studioLvl_ff <= (wLvl[15:8] > monitor_solo_pkg::STUDIO_LVL_MAX) ?
                      monitor_solo_pkg::STUDIO_LVL_MAX : wLvl[15:8];
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      soloOn_ff <= 1'b0;
      soloExcl_ff <= 1'b0;
      soloLink_ff <= monitor_solo_pkg::LINK_OFF;
      soloType_ff <= monitor_solo_pkg::SOLO_PFL;
      defeat_ff <= 32'h0000_0000;
      grpSel_ff <= 4'h0;
    end else if (doWrite) begin
      if (selSolo) begin
        soloOn_ff <= wSolo[0];
        soloExcl_ff <= wSolo[1];
        if (wSolo[3:2] != 2'h3) soloLink_ff <= wSolo[3:2];
        if (wSolo[5:4] != 2'h3) soloType_ff <= monitor_solo_pkg::solo_type_t'(wSolo[5:4]);
      end
      if (selDefeat) defeat_ff <= merge(defeat_ff);
      if (selGrp) grpSel_ff <= wGrp[3:0];
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int g = 0; g < 16; g++) begin
        grpMem_ff[g] <= 32'h0000_0000;
        grpMaster_ff[g] <= 6'h00;
      end
    end else if (doWrite) begin
      if (selMem) grpMem_ff[grpSel_ff] <= merge(grpMem_ff[grpSel_ff]);
      if (selMaster) grpMaster_ff[grpSel_ff] <= {wData_ff[8], wData_ff[4:0]};
    end
  end
  // ---------------------------------------------------------------
  // Solo engine
  // ---------------------------------------------------------------
  logic press;
  logic [4:0] pressCh;
  logic [31:0] pressBit;
  logic isMaster;
  logic [31:0] grpBits;
  logic [31:0] nxt_soloMask;
  // The channel index is five bits wide, so only input channels exist here
  assign press = doWrite && selPress && wStrb_ff[0];
  assign pressCh = wData_ff[4:0];
  assign pressBit = 32'h0000_0001 << pressCh;
  always_comb begin
    isMaster = 1'b0;
    grpBits = 32'h0000_0000;
    for (int g = 0; g < monitor_solo_pkg::NUM_GRP; g++) begin
      logic [3:0] idx;
      idx = {soloLink_ff == monitor_solo_pkg::LINK_FADER, 3'(g)};
      if (soloLink_ff != monitor_solo_pkg::LINK_OFF && grpMaster_ff[idx][5] &&
          grpMaster_ff[idx][4:0] == pressCh) begin
        isMaster = 1'b1;
        grpBits = grpBits | grpMem_ff[idx] | pressBit;
      end
    end
  end
  always_comb begin
    nxt_soloMask = soloMask_ff;
    if (isMaster) begin
      // Master toggles its group in either mode
      if ((soloMask_ff & pressBit) != 32'h0000_0000) nxt_soloMask = soloMask_ff & ~grpBits;
      else if (soloExcl_ff) nxt_soloMask = grpBits;
      else nxt_soloMask = soloMask_ff | grpBits;
    end else if (soloExcl_ff) begin
      // Slave or plain channel clears itself if soloed, else becomes the only soloed channel
      nxt_soloMask = ((soloMask_ff & pressBit) != 32'h0000_0000) ?
                     (soloMask_ff & ~pressBit) : pressBit;
    end else begin
      nxt_soloMask = soloMask_ff ^ pressBit;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) soloMask_ff <= 32'h0000_0000;
    else if (press) soloMask_ff <= nxt_soloMask;
  end
  // ---------------------------------------------------------------
  // Source resolution
  // ---------------------------------------------------------------
  logic [4:0] crSrc;
  logic [4:0] crL;
  logic [4:0] crR;
  logic linkable;
  logic crOddFirst;
  assign crSrc = (crKey_ff == 2'h0) ? monitor_solo_pkg::SRC_STEREO : keySrc_ff[crKey_ff - 2'h1];
  assign linkable = (crSrc >= monitor_solo_pkg::SRC_AUX1 && crSrc < monitor_solo_pkg::SRC_AUX12) ||
                    (crSrc >= monitor_solo_pkg::SRC_BUS1 && crSrc <= monitor_solo_pkg::SRC_BUS8);
  // Aux numbers equal their code; bus codes are offset by an odd amount
  assign crOddFirst = (crSrc < monitor_solo_pkg::SRC_BUS1) ? crSrc[0] : !crSrc[0];
  always_comb begin
    crL = crSrc;
    crR = crSrc;
    if (followLink_ff && linkable) begin
      crL = crOddFirst ? crSrc : crSrc - 5'h01;
      crR = crL + 5'h01;
    end
  end
  logic crDigital;
  logic [5:0] dimDb;
  assign crDigital = crDig_ff != monitor_solo_pkg::DIG_NONE;
  always_comb begin
    dimDb = 6'h00;
    if (dimOn_ff) begin
      dimDb = (crSrc == monitor_solo_pkg::SRC_2TR) ? monitor_solo_pkg::DIM_2TR_DB : dimLevel_ff;
    end
  end
  // ---------------------------------------------------------------
  // Outputs, committed only on a sample boundary
  // ---------------------------------------------------------------
  logic soloLive;
  assign soloLive = soloOn_ff && soloMask_ff != 32'h0000_0000;
  always_ff @(posedge clk) begin
    if (rst) begin
      mon <= '0;
    end else if (sampleTick) begin
      mon.crLeft <= crL;
      mon.crRight <= crR;
      mon.crMuted <= crDigital && crSrc == monitor_solo_pkg::SRC_2TR;
      mon.digOut1 <= crDig_ff == monitor_solo_pkg::DIG_SET1;
      mon.digOut2 <= crDig_ff == monitor_solo_pkg::DIG_SET2;
      mon.dimAtten <= dimDb;
      mon.studioLevel <= studioLvl_ff;
      if (studioFollow_ff) begin
        mon.studioLeft <= crL;
        mon.studioRight <= crR;
        mon.studioMuted <= crDigital && crSrc == monitor_solo_pkg::SRC_2TR;
      end else begin
        mon.studioLeft <= studioSrc_ff;
        mon.studioRight <= studioSrc_ff;
        mon.studioMuted <= 1'b0;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      solo <= '0;
    end else if (sampleTick) begin
      solo.active <= soloLive;
      solo.preFaderTap <= (soloLive && soloType_ff == monitor_solo_pkg::SOLO_PFL) ?
                          soloMask_ff : 32'h0000_0000;
      solo.afterFaderTap <= (soloLive && soloType_ff == monitor_solo_pkg::SOLO_AFL) ?
                            soloMask_ff : 32'h0000_0000;
      solo.stereoCut <= (soloLive && soloType_ff == monitor_solo_pkg::SOLO_INPLACE) ?
                        (~soloMask_ff & ~defeat_ff) : 32'h0000_0000;
    end
  end
  // ---------------------------------------------------------------
  // AXI4-Lite read channel
  // ---------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= monitor_solo_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= monitor_solo_pkg::RESP_OKAY;
      if (s_axi_araddr == monitor_solo_pkg::OFS_MON_CTRL)
        s_axi_rdata <= {19'h0, studioSrc_ff, 1'b0, dimOn_ff, followLink_ff, studioFollow_ff,
                        crDig_ff, crKey_ff};
      else if (s_axi_araddr == monitor_solo_pkg::OFS_KEY_SRC)
        s_axi_rdata <= {11'h0, keySrc_ff[2], 3'h0, keySrc_ff[1], 3'h0, keySrc_ff[0]};
      else if (s_axi_araddr == monitor_solo_pkg::OFS_LEVELS)
        s_axi_rdata <= {16'h0, studioLvl_ff, 2'h0, dimLevel_ff};
      else if (s_axi_araddr == monitor_solo_pkg::OFS_SOLO_CTRL)
        s_axi_rdata <= {26'h0, soloType_ff, soloLink_ff, soloExcl_ff, soloOn_ff};
      else if (s_axi_araddr == monitor_solo_pkg::OFS_SOLO_PRESS)
        s_axi_rdata <= soloMask_ff;
      else if (s_axi_araddr == monitor_solo_pkg::OFS_SOLO_DEFEAT)
        s_axi_rdata <= defeat_ff;
      else if (s_axi_araddr == monitor_solo_pkg::OFS_GROUP_SEL)
        s_axi_rdata <= {28'h0, grpSel_ff};
      else if (s_axi_araddr == monitor_solo_pkg::OFS_GROUP_MEMBERS)
        s_axi_rdata <= grpMem_ff[grpSel_ff];
      else if (s_axi_araddr == monitor_solo_pkg::OFS_GROUP_MASTER)
        s_axi_rdata <= {23'h0, grpMaster_ff[grpSel_ff][5], 3'h0, grpMaster_ff[grpSel_ff][4:0]};
      else if (s_axi_araddr == monitor_solo_pkg::OFS_STATUS)
        s_axi_rdata <= {7'h0, soloLive, 6'h0, mon.studioMuted, mon.crMuted, 3'h0, crR, 3'h0, crL};
      else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= monitor_solo_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_DIG_EXCLUSIVE: assert property (!(mon.digOut1 && mon.digOut2))
    else $error("both digital sets carry the control room");
  AST_STEREO_KEY: assert property (sampleTick && crKey_ff == 2'h0 |=>
    mon.crLeft == monitor_solo_pkg::SRC_STEREO && mon.crRight == monitor_solo_pkg::SRC_STEREO)
    else $error("stereo key did not give stereo bus");
  AST_DIM_2TR: assert property (sampleTick && dimOn_ff && crSrc == monitor_solo_pkg::SRC_2TR
    |=> mon.dimAtten == monitor_solo_pkg::DIM_2TR_DB)
    else $error("two-track dim not fixed");
  AST_2TR_DIGITAL: assert property (sampleTick && crDigital &&
    crSrc == monitor_solo_pkg::SRC_2TR |=> mon.crMuted)
    else $error("two-track monitored while feed is digital");
  AST_FOLLOW: assert property (sampleTick && studioFollow_ff |=>
    mon.studioLeft == mon.crLeft && mon.studioRight == mon.crRight)
    else $error("studio does not follow control room");
  AST_STUDIO_MAX: assert property (mon.studioLevel <= monitor_solo_pkg::STUDIO_LVL_MAX)
    else $error("studio level above maximum");
  AST_SOLO_GATE: assert property (!solo.active |-> solo.stereoCut == 32'h0000_0000 &&
    solo.preFaderTap == 32'h0000_0000 && solo.afterFaderTap == 32'h0000_0000)
    else $error("solo effect without active solo");
  AST_MIX_TOGGLE: assert property (press && !soloExcl_ff && !isMaster |=>
    soloMask_ff == ($past(soloMask_ff) ^ $past(pressBit)))
    else $error("mix solo did not toggle channel");
  AST_EXCL_ONE: assert property (press && soloExcl_ff && !isMaster &&
    (soloMask_ff & pressBit) == 32'h0000_0000 |=> soloMask_ff == $past(pressBit))
    else $error("exclusive solo kept other channels");
  AST_INPLACE: assert property (sampleTick && soloLive &&
    soloType_ff == monitor_solo_pkg::SOLO_INPLACE |=>
    solo.stereoCut == ~($past(soloMask_ff) | $past(defeat_ff)))
    else $error("in-place cut wrong");
  AST_DEFEAT: assert property (sampleTick |=> (solo.stereoCut & $past(defeat_ff)) == 32'h0000_0000)
    else $error("exempt channel cut");
  AST_HOLD: assert property (!sampleTick |=> $stable(mon) && $stable(solo))
    else $error("output changed off sample boundary");
  COV_INPLACE: cover property (solo.active && solo.stereoCut != 32'h0000_0000);
  COV_GROUP: cover property (press && isMaster ##1 soloMask_ff != 32'h0000_0000);
  COV_LINKED: cover property (mon.crLeft != mon.crRight);
endmodule // monitor_source_and_solo_control

// >>> tb_top.sv
// Self-checking testbench of the monitor source and solo control block
`timescale 1ns/1ns
module tb_top;
  logic clk = 0, rst = 1, sampleTick = 0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, lf = 32'hd30c, v;
  monitor_solo_pkg::monitor_out_t mon;
  monitor_solo_pkg::solo_out_t solo;
  logic [1:0] bq[$];
  logic [33:0] rq[$];
  int num_errors = 0, checks = 0, cyc = 0;
  always #10 clk = ~clk;
  monitor_source_and_solo_control i_monitor_source_and_solo_control (.clk(clk), .rst(rst),
    .sampleTick(sampleTick), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .mon(mon), .solo(solo));
  // ----------------------------------------
  // Reporting
  // ----------------------------------------
  task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Response watcher pairs each answer with the oldest note
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      close_out();
    end
    if (bvalid && bready) chk("bresp", {32'h0, bq.pop_front()}, {32'h0, bresp});
    if (rvalid && rready) chk("rdata", rq.pop_front(), {rresp, rdata});
  end
  // ----------------------------------------
  // Bus and sample tasks
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0,
    input logic [3:0] s = 4'hf);
    logic ta, tw, da, dw, b;
    {da, dw} = 2'b00;
    @(posedge clk);
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!(da && dw)) begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge clk);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
      da |= ta;
      dw |= tw;
    end
    do begin
      @(negedge clk);
      b = bvalid;
      @(posedge clk);
    end while (!b);
    bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0);
    logic t;
    @(posedge clk);
    rq.push_back({r, e});
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(negedge clk);
      t = arvalid && arready;
      @(posedge clk);
    end while (!t);
    arvalid <= 0;
    do begin
      @(negedge clk);
      t = rvalid;
      @(posedge clk);
    end while (!t);
    rready <= 0;
  endtask
  task automatic tick();
    @(posedge clk);
    sampleTick <= 1;
    @(posedge clk);
    sampleTick <= 0;
    repeat (2) @(posedge clk);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rst <= 0;
    rd(8'h00, 32'h10);
    rd(8'h04, 32'h00181607);
    $display("reset values done");
    wr(8'h00, 32'h53);
    tick();
    chk("crLeft", 34'd24, mon.crLeft);
    chk("dim", 34'd30, mon.dimAtten);
    chk("studioLeft", 34'd24, mon.studioLeft);
    wr(8'h00, 32'h57);
    tick();
    chk("dig", 34'h2, {mon.digOut1, mon.digOut2});
    chk("muted", 34'h3, {mon.crMuted, mon.studioMuted});
    $display("two-track done");
    wr(8'h04, 32'h00030303);
    lf = lfsr(lf);
    v = lf % 41;
    wr(8'h08, {16'h0, 8'hff, v[7:0]});
    wr(8'h00, 32'h71);
    tick();
    chk("pair", {24'h0, 5'd3, 5'd4}, {mon.crLeft, mon.crRight});
    chk("dimlvl", {2'b0, v}, mon.dimAtten);
    chk("studioLvl", 34'h8a, mon.studioLevel);
    wr(8'h00, 32'h10);
    tick();
    chk("stereo", 34'h0, mon.crLeft);
    $display("sources done");
    wr(8'h0c, 32'h21);
    wr(8'h10, 32'h3);
    wr(8'h10, 32'h5);
    wr(8'h14, 32'h1);
    rd(8'h10, 32'h28);
    tick();
    chk("active", 34'h1, solo.active);
    chk("cut", {2'b0, ~32'h29}, solo.stereoCut);
    wr(8'h0c, 32'h03);
    wr(8'h10, 32'h7);
    rd(8'h10, 32'h80);
    tick();
    chk("pfl", 34'h80, solo.preFaderTap);
    chk("nocut", 34'h0, solo.stereoCut);
    $display("solo done");
    wr(8'h18, 32'h0);
    wr(8'h1c, 32'h300);
    wr(8'h20, 32'h10a);
    rd(8'h20, 32'h10a);
    wr(8'h0c, 32'h17);
    wr(8'h10, 32'ha);
    rd(8'h10, 32'h700);
    wr(8'h10, 32'h9);
    rd(8'h10, 32'h500);
    tick();
    chk("afl", 34'h500, solo.afterFaderTap);
    chk("noPfl", 34'h0, solo.preFaderTap);
    rd(8'h24, 32'h0100_0000);
    wr(8'h10, 32'ha, 2'h0, 4'he);
    rd(8'h10, 32'h500);
    wr(8'h10, 32'ha);
    rd(8'h10, 32'h0);
    $display("groups done");
    wr(8'h00, 32'h1804);
    tick();
    chk("studio", {23'h0, 5'd24, 5'd24, 1'b0},
      {mon.studioLeft, mon.studioRight, mon.studioMuted});
    $display("studio done");
    rd(8'h28, 32'h0, 2'h2);
    wr(8'h24, 32'h1, 2'h2);
    $display("errors done");
    repeat (4) @(posedge clk);
    close_out();
  end
endmodule // tb_top
